// ===== design/aperture_delay_ramp_control.sv
// Purpose: Aperture delay control with coarse code slewing
// Assumes: i_clock is the sampling clock domain, synchronous active-low reset
// Notes:   Avalon-MM slave, one wait state on every access
//
// Summary of operation
// - Fine code sets fine delay when autocal off
// - Fine code writes apply anytime, glitch free
// - Slew one or four codes per 384 cycles
// - Rate select matters only with slew enabled
// - Slew off: coarse applied within 1536 cycles
// - Slew on: step gradually, stop at target
// - Coarse code sets coarse delay when autocal off
// - Invert bit inverts the sampling clock
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module aperture_delay_ramp_control
  import aperture_delay_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_PERIOD_CYC
)(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic [13:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic        i_sysref_autocal_enable,
  input  wire logic [7:0]  i_autocal_fine,
  input  wire logic [7:0]  i_autocal_coarse,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output delay_setting_t   o_delay_setting,
  output logic             o_slew_busy
);

  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

  typedef enum logic [1:0] {IDLE, DIRECT, SLEW} mode_t;

  logic [23:0]      adjust_r;
  logic [7:0]       slew_ctrl_r;
  logic [7:0]       applied_coarse_r;
  logic [7:0]       applied_coarse_nxt;
  logic [CNT_W-1:0] step_cnt_r;
  logic             ack_r;
  logic             coarse_written;
  logic             step_tick;
  logic             access;
  logic [31:0]      rdata;
  logic [7:0]       target;
  logic [7:0]       step_size;
  logic [7:0]       diff;
  logic [1:0]       direct_cnt_r;
  mode_t            mode_r;

  // A request is taken only while no answer is pending
  assign access = (i_avs_read || i_avs_write) && !ack_r;
  assign target = adjust_r[COARSE_LSB +: 8];

  // One wait state: first cycle asserts waitrequest, second completes
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      ack_r <= 1'b0;
    else
      ack_r <= access;
  end

  // Own flop so the bus sees no logic after the register
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_avs_waitrequest <= 1'b1;
    else
      o_avs_waitrequest <= !access;
  end

  // Register writes take effect at the completing edge
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      adjust_r    <= ADJUST_RESET;
      slew_ctrl_r <= SLEW_CTRL_RESET;
    end
    else if (ack_r && i_avs_write)
    begin
      if (i_avs_address == ADJUST_ADDR)
      begin
        if (i_avs_byteenable[0])
          adjust_r[7:0] <= i_avs_writedata[7:0];
        if (i_avs_byteenable[1])
          adjust_r[15:8] <= i_avs_writedata[15:8];
        if (i_avs_byteenable[2])
          adjust_r[23:16] <= i_avs_writedata[23:16];
      end
      else if (i_avs_address == SLEW_CTRL_ADDR && i_avs_byteenable[0])
        slew_ctrl_r <= i_avs_writedata[7:0];
    end
  end

  // Only a write that carries the coarse byte starts a new sequence
  assign coarse_written = ack_r && i_avs_write && i_avs_address == ADJUST_ADDR
                          && i_avs_byteenable[1];

  always_comb
  begin
    rdata = UNMAPPED_READ;
    case (i_avs_address)
      ADJUST_ADDR:    rdata = {8'h00, adjust_r};
      SLEW_CTRL_ADDR: rdata = {24'h00_0000, slew_ctrl_r};
      APPLIED_ADDR:   rdata = {23'h00_0000, mode_r != IDLE, applied_coarse_r};
      default:        rdata = UNMAPPED_READ;
    endcase
  end

  // Captured at the taking edge so it stands at the completing edge
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_avs_readdata <= UNMAPPED_READ;
    else if (access && i_avs_read)
      o_avs_readdata <= rdata;
  end

  // Rate is sampled live; it only acts while in slew mode
  always_comb
  begin
    step_size = slew_ctrl_r[RATE_SEL_BIT] ? FAST_STEP : SLOW_STEP;
    diff = (target > applied_coarse_r) ? target - applied_coarse_r
                                       : applied_coarse_r - target;
    if (diff < step_size)
      step_size = diff;
    applied_coarse_nxt = (target > applied_coarse_r) ? applied_coarse_r + step_size
                                                     : applied_coarse_r - step_size;
  end

  // Step divider: a coarse write restarts it, so every ramp waits a full period
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      step_cnt_r <= '0;
    else if (coarse_written || step_tick)
      step_cnt_r <= '0;
    else if (mode_r == SLEW)
      step_cnt_r <= step_cnt_r + 1'b1;
  end

  assign step_tick = (mode_r == SLEW) && (step_cnt_r == STEP_LAST);

  // Coarse sequencing: a new write restarts the chosen mode
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      mode_r           <= IDLE;
      applied_coarse_r <= 8'h00;
      direct_cnt_r     <= 2'b00;
    end
    else if (coarse_written)
    begin
      direct_cnt_r <= 2'b00;
      mode_r       <= slew_ctrl_r[SLEW_EN_BIT] ? SLEW : DIRECT;
    end
    else
    begin
      case (mode_r)
        IDLE:
          mode_r <= IDLE;
        DIRECT:
        begin
          // Short settle well inside the 1536-cycle limit
          direct_cnt_r <= direct_cnt_r + 2'b01;
          if (direct_cnt_r == 2'(DIRECT_DELAY_CYC - 1))
          begin
            applied_coarse_r <= target;
            mode_r           <= IDLE;
          end
        end
        SLEW:
        begin
          // Match is tested first, so a write of the present value ends at once
          if (applied_coarse_r == target)
            mode_r <= IDLE;
          else if (step_tick)
            applied_coarse_r <= applied_coarse_nxt;
        end
        default:
          mode_r <= IDLE;
      endcase
    end
  end

  // Autocal overrides manual codes
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_delay_setting <= '0;
    else
    begin
      o_delay_setting.invert <= adjust_r[INVERT_BIT];
      o_delay_setting.fine   <= i_sysref_autocal_enable ? i_autocal_fine
                                                        : adjust_r[FINE_LSB +: 8];
      o_delay_setting.coarse <= i_sysref_autocal_enable ? i_autocal_coarse
                                                        : applied_coarse_r;
    end
  end

  // Busy covers both the direct settle and the ramp, so software polls one bit
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_slew_busy <= 1'b0;
    else
      o_slew_busy <= (mode_r != IDLE);
  end

endmodule : aperture_delay_ramp_control

// ===== common/aperture_delay_pkg.sv
// Purpose: Constants and types for the aperture delay ramp control block
// Assumes: Avalon-MM slave, 32-bit data, byte addressing
// Notes:   Register indexes are kept as printed; byte address is four times the index
package aperture_delay_pkg;

  localparam logic [11:0] ADJUST_INDEX      = 12'h2B5;
  localparam logic [11:0] SLEW_CTRL_INDEX   = 12'h2B8;
  localparam logic [11:0] APPLIED_INDEX     = 12'h2B9;
  localparam logic [13:0] ADJUST_ADDR       = {ADJUST_INDEX, 2'b00};
  localparam logic [13:0] SLEW_CTRL_ADDR    = {SLEW_CTRL_INDEX, 2'b00};
  localparam logic [13:0] APPLIED_ADDR      = {APPLIED_INDEX, 2'b00};

  localparam int          FINE_LSB          = 0;
  localparam int          COARSE_LSB        = 8;
  localparam int          INVERT_BIT        = 16;
  localparam int          SLEW_EN_BIT       = 0;
  localparam int          RATE_SEL_BIT      = 1;
  localparam int          APPLIED_BUSY_BIT  = 8;

  localparam logic [23:0] ADJUST_RESET      = 24'h00_0000;
  localparam logic [7:0]  SLEW_CTRL_RESET   = 8'h00;
  localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

  localparam int          STEP_PERIOD_CYC   = 384;
  localparam int          DIRECT_LIMIT_CYC  = 1536;
  localparam int          DIRECT_DELAY_CYC  = 2;
  localparam logic [7:0]  SLOW_STEP         = 8'h01;
  localparam logic [7:0]  FAST_STEP         = 8'h04;

  typedef struct packed {
    logic       invert;
    logic [7:0] coarse;
    logic [7:0] fine;
  } delay_setting_t;

endpackage : aperture_delay_pkg

// ===== tb/aperture_delay_ramp_control_asserts.sv
// Purpose: Port checks for the delay ramp block
// Assumes: One clock, sync active-low reset
// Notes:   Slew enable is tracked from seen writes
`timescale 1ns/1ps
module aperture_delay_ramp_control_checker
  import aperture_delay_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic [13:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        i_sysref_autocal_enable,
  input wire logic [7:0]  i_autocal_fine,
  input wire logic [7:0]  i_autocal_coarse,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input delay_setting_t   o_delay_setting,
  input wire logic        o_slew_busy
);
  logic slew_r;
  wire  wr = i_avs_write && !o_avs_waitrequest;
  wire  adj = wr && i_avs_address == ADJUST_ADDR && !i_sysref_autocal_enable;
  wire  ac = i_sysref_autocal_enable;
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      slew_r <= 1'b0;
    else if (wr && i_avs_address == SLEW_CTRL_ADDR)
      slew_r <= i_avs_writedata[0];
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  chk_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("no answer");
  chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("long answer");
  chk_fine_write: assert property (adj ##1 !ac |=>
    o_delay_setting.fine == 8'($past(i_avs_writedata, 2))) else $error("fine");
  chk_invert_bit: assert property (adj |=> ##1
    o_delay_setting.invert == 1'($past(i_avs_writedata, 2) >> 16)) else $error("invert");
  chk_autocal_codes: assert property ($past(ac) && $past(i_rstn) |->
    o_delay_setting[15:0] == $past({i_autocal_coarse, i_autocal_fine})) else $error("cal");
  chk_reset_state: assert property (disable iff (1'b0) !i_rstn |=>
    o_delay_setting == '0 && o_avs_waitrequest && !o_slew_busy) else $error("reset");
  chk_step_size: assert property (slew_r && $past(slew_r, 3) && !ac && !$past(ac, 3)
    && $changed(o_delay_setting.coarse) |-> 8'(o_delay_setting.coarse
    - $past(o_delay_setting.coarse)) + 8'h04 <= 8'h08) else $error("step");
  chk_unmapped_read: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address
    > APPLIED_ADDR |=> o_avs_readdata == UNMAPPED_READ) else $error("unmapped");
  cover property (wr);
  cover property ($rose(o_slew_busy));
  cover property (ac && !o_slew_busy);
endmodule : aperture_delay_ramp_control_checker

// ===== tb/aperture_delay_ramp_control_test.sv
// Purpose: Directed bench for the delay ramp block
// Assumes: Step period cut to 8 cycles
// Notes:   Accesses wait on the slave, cut by timeout
`timescale 1ns/1ps
module aperture_delay_ramp_control_test;
  import aperture_delay_pkg::*;
  localparam int SC = 8;
  logic           i_clock, i_rstn, i_avs_read, i_avs_write, i_sysref_autocal_enable;
  logic [13:0]    i_avs_address;
  logic [31:0]    i_avs_writedata, o_avs_readdata, q;
  logic [3:0]     i_avs_byteenable;
  logic [7:0]     i_autocal_fine, i_autocal_coarse;
  logic           o_avs_waitrequest, o_slew_busy;
  delay_setting_t o_delay_setting;
  int             error_cnt, total_checks, cyc, n;
  aperture_delay_ramp_control #(.STEP_CYCLES(SC)) dut_u (.i_clock, .i_rstn, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .i_sysref_autocal_enable,
    .i_autocal_fine, .i_autocal_coarse, .o_avs_readdata, .o_avs_waitrequest,
    .o_delay_setting, .o_slew_busy);
  initial
  begin
    i_clock = 0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do @(posedge i_clock); while (o_avs_waitrequest);
    q = o_avs_readdata;
    i_avs_write <= 0;
    i_avs_read <= 0;
  endtask : acc
  task automatic wt(input logic [7:0] t);
    n = 0;
    while (o_delay_setting.coarse !== t) @(negedge i_clock) n++;
  endtask : wt
  task automatic t_direct();
    acc(0, SLEW_CTRL_ADDR, 0);
    chk(q, 0);
    acc(1, SLEW_CTRL_ADDR, 2); // Rate set with slewing off
    acc(1, ADJUST_ADDR, 32'h1_10A5);
    wt(8'h10);
    chk(n < SC, 1);
    chk(o_delay_setting, 32'h1_10A5);
    acc(0, ADJUST_ADDR, 0);
    chk(q, 32'h1_10A5);
    acc(0, APPLIED_ADDR, 0);
    chk(q, 32'h10);
  endtask : t_direct
  task automatic t_slew(input logic [31:0] c, input logic [7:0] t);
    acc(1, SLEW_CTRL_ADDR, c);
    acc(1, ADJUST_ADDR, {16'h0, t, 8'hA5});
    repeat (2) @(negedge i_clock);
    chk(o_slew_busy, 1);
    wt(t);
    chk(n >= 2 * SC && n <= 3 * SC + 8, 1);
    repeat (2) @(negedge i_clock);
    chk(o_slew_busy, 0);
  endtask : t_slew
  task automatic t_other();
    acc(1, SLEW_CTRL_ADDR, 0);
    @(posedge i_clock);
    i_sysref_autocal_enable <= 1;
    repeat (3) @(negedge i_clock);
    chk(o_delay_setting[15:0], 16'h5C3C);
    @(posedge i_clock);
    i_sysref_autocal_enable <= 0;
    acc(1, 14'h0AE8, 32'hFFFF_FFFF);
    acc(0, 14'h0AE8, 0);
    chk(q, UNMAPPED_READ);
    chk(o_delay_setting.fine, 8'hA5);
    chk(o_delay_setting, 32'h0_17A5);
  endtask : t_other
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial
  begin
    {i_rstn, i_avs_read, i_avs_write, i_sysref_autocal_enable, i_avs_address} = '0;
    {i_avs_writedata, i_avs_byteenable, i_autocal_fine, i_autocal_coarse} = 52'h0_F3C5C;
    repeat (12) @(posedge i_clock);
    i_rstn <= 1;
    t_direct();
    t_slew(32'h3, 8'h1A);
    t_slew(32'h1, 8'h17);
    t_other();
    test_done();
  end
endmodule : aperture_delay_ramp_control_test
bind aperture_delay_ramp_control aperture_delay_ramp_control_checker chk_u (.i_clock, .i_rstn,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .i_sysref_autocal_enable, .i_autocal_fine, .i_autocal_coarse, .o_avs_readdata,
  .o_avs_waitrequest, .o_delay_setting, .o_slew_busy);
